// file: inc/dir_oc_pkg.sv
package dir_oc_pkg;

  localparam int MAG_W = 16;
  localparam int ANG_W = 10;
  localparam int TMR_W = 32;

  // fractions of rated value, in percent
  localparam int VOLT_MIN_PCT = 5;
  localparam int CURR_MIN_PCT = 8;

  // processing tick of the measurement blocks
  localparam int TICK_US = 1000;
  localparam int CLK_MHZ = 50;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [15:0] TICK_DIV = 16'(TICK_CYCLES - 1);

  localparam logic [TMR_W-1:0] TMR_RESET = 32'h00000000;
  localparam logic [2:0] LOOP_RESET = 3'h0;
  localparam int NUM_LOOPS = 6;
  localparam int NUM_PP = 3;

  typedef enum logic [1:0] {
    DIR_FORWARD,
    DIR_BACKWARD,
    DIR_NONE
  } dir_mode_t;

  typedef enum logic [2:0] {
    CHAR_DEFINITE,
    CHAR_NORMAL_INV,
    CHAR_VERY_INV,
    CHAR_EXTREME_INV,
    CHAR_LONG_INV
  } char_sel_t;

  typedef enum logic {
    GND_SOLID,
    GND_ISOLATED
  } grounding_t;

  // one measuring loop: voltage, current, impedance estimate, angle
  typedef struct packed {
    logic [MAG_W-1:0] volt;
    logic [MAG_W-1:0] curr;
    logic [MAG_W-1:0] imp;
    logic [ANG_W-1:0] angle;
  } loop_meas_t;

  // polarising and magnitude inputs shared by all loops
  typedef struct packed {
    logic [MAG_W-1:0] pos_seq_volt;
    logic [ANG_W-1:0] pos_seq_angle;
    logic [MAG_W-1:0] rated_volt;
    logic [MAG_W-1:0] rated_curr;
  } polar_meas_t;

  typedef struct packed {
    dir_mode_t direction;
    char_sel_t characteristic;
    grounding_t grounding_type_sel;
    logic direction_ignored_on_vt_fail;
    logic use_rms;
    logic [ANG_W-1:0] angle_lo;
    logic [ANG_W-1:0] angle_hi;
    logic [MAG_W-1:0] start_curr;
    logic [TMR_W-1:0] delay_ticks;
  } oc_config_t;

endpackage : dir_oc_pkg

// file: logic/oc_delay_timer.sv
// delay timer on processing ticks, definite or inverse
module oc_delay_timer
  import dir_oc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic tick,
  input wire logic run,
  input wire dir_oc_pkg::char_sel_t characteristic,
  input wire logic [dir_oc_pkg::TMR_W-1:0] delay_ticks,
  input wire logic [dir_oc_pkg::MAG_W-1:0] curr,
  input wire logic [dir_oc_pkg::MAG_W-1:0] start_curr,
  // result
  output logic expired
);
  import dir_oc_pkg::*;

  logic [TMR_W-1:0] acc;
  logic [TMR_W-1:0] next_acc;
  logic [TMR_W-1:0] step;
  logic [TMR_W-1:0] target;
  logic [2:0] ratio_log;

  // rough log2 of multiple of setting, curve steepness per type
  function automatic logic [2:0] mult_log(input logic [MAG_W-1:0] i,
                                          input logic [MAG_W-1:0] s);
    logic [MAG_W+3:0] iw;
    logic [MAG_W+3:0] sw;
    logic [2:0] r;
    // widened so a shifted setting cannot wrap
    iw = (MAG_W + 4)'(i);
    sw = (MAG_W + 4)'(s);
    r = 3'h0;
    if (iw >= (sw << 1)) r = 3'h1;
    if (iw >= (sw << 2)) r = 3'h2;
    if (iw >= (sw << 3)) r = 3'h3;
    if (iw >= (sw << 4)) r = 3'h4;
    return r;
  endfunction : mult_log

  assign ratio_log = mult_log(curr, start_curr);
  assign target = delay_ticks;
  // inverse curves advance faster as the current grows
  assign step = (characteristic == CHAR_DEFINITE) ? 32'h00000001 :
    (characteristic == CHAR_NORMAL_INV) ? (32'h00000001 << ratio_log) :
    (characteristic == CHAR_VERY_INV) ? (32'h00000001 << (ratio_log * 2)) :
    (characteristic == CHAR_EXTREME_INV) ?
      (32'h00000001 << (ratio_log * 3)) :
    (32'h00000001 << (ratio_log >> 1));
  assign next_acc = !run ? TMR_RESET :
    (tick && acc < target) ? acc + step : acc;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= TMR_RESET;
      expired <= 1'b0;
    end else begin
      acc <= next_acc;
      expired <= run && (next_acc >= target);
    end
  end

endmodule : oc_delay_timer

// file: logic/dir_overcurrent_stage.sv
module dir_overcurrent_stage
  import dir_oc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // measurements, loops 0..2 phase-phase, 3..5 phase-ground
  input wire dir_oc_pkg::loop_meas_t loops [dir_oc_pkg::NUM_LOOPS],
  input wire dir_oc_pkg::polar_meas_t polar,
  input wire logic [dir_oc_pkg::MAG_W-1:0] curr_rms [3],
  input wire logic [dir_oc_pkg::MAG_W-1:0] curr_four [3],
  // settings
  input wire dir_oc_pkg::oc_config_t cfg,
  // binary inputs, asynchronous to this block
  input wire logic block_in,
  input wire logic voltage_circuit_failed,
  input wire logic close_onto_fault_cond,
  // outputs
  output logic [2:0] start_phase,
  output logic general_start,
  output logic trip,
  output logic dir_ok,
  output logic [2:0] lowest_impedance_loop_sel
);
  import dir_oc_pkg::*;

  logic [2:0] blk_s1, blk_s2;
  logic [15:0] div_cnt;
  logic tick;
  logic [MAG_W-1:0] mem_volt;
  logic [ANG_W-1:0] mem_angle;
  logic direction_ignored;
  logic func_blocked;

  // two-flop synchronisers for the binary inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_s1 <= 3'h0;
      blk_s2 <= 3'h0;
    end else begin
      blk_s1 <= {close_onto_fault_cond, voltage_circuit_failed, block_in};
      blk_s2 <= blk_s1;
    end
  end

  wire blk_q = blk_s2[0];
  wire vtf_q = blk_s2[1];
  wire sotf_q = blk_s2[2];

  // processing tick divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == TICK_DIV) ? 16'h0000 : div_cnt + 16'h0001;
      tick <= (div_cnt == TICK_DIV);
    end
  end

  // percentage threshold test, used for voltage and current
  function automatic logic above_pct(input logic [MAG_W-1:0] val,
                                     input logic [MAG_W-1:0] rated,
                                     input int pct, input logic strict);
    logic [MAG_W+7:0] lhs;
    logic [MAG_W+7:0] rhs;
    lhs = (MAG_W + 8)'(val) * (MAG_W + 8)'(100);
    rhs = (MAG_W + 8)'(rated) * (MAG_W + 8)'(pct);
    return strict ? (lhs > rhs) : (lhs >= rhs);
  endfunction : above_pct

  // angle window test, wraps when lo above hi
  function automatic logic in_range(input logic [ANG_W-1:0] a,
                                    input logic [ANG_W-1:0] lo,
                                    input logic [ANG_W-1:0] hi);
    return (lo <= hi) ? (a >= lo && a <= hi) : (a >= lo || a <= hi);
  endfunction : in_range

  // loop eligibility and minimum impedance search
  logic [NUM_LOOPS-1:0] loop_ok;
  logic [2:0] best;
  logic found;

  always_comb begin
    best = LOOP_RESET;
    found = 1'b0;
    for (int k = 0; k < NUM_LOOPS; k++) begin
      loop_ok[k] = above_pct(loops[k].volt, polar.rated_volt, VOLT_MIN_PCT,
                             1'b1) &&
                   above_pct(loops[k].curr, polar.rated_curr, CURR_MIN_PCT,
                             1'b0) &&
                   (k < NUM_PP || cfg.grounding_type_sel == GND_SOLID);
      if (loop_ok[k] && (!found || loops[k].imp < loops[best].imp)) begin
        best = 3'(k);
        found = 1'b1;
      end
    end
  end

  // fall back to current-only loops when voltage is short
  logic [NUM_LOOPS-1:0] curr_ok;
  logic [2:0] cbest;
  logic cfound;

  always_comb begin
    cbest = LOOP_RESET;
    cfound = 1'b0;
    for (int k = 0; k < NUM_LOOPS; k++) begin
      curr_ok[k] = above_pct(loops[k].curr, polar.rated_curr, CURR_MIN_PCT,
                             1'b0) &&
                   (k < NUM_PP || cfg.grounding_type_sel == GND_SOLID);
      if (curr_ok[k] && (!cfound || loops[k].imp < loops[cbest].imp)) begin
        cbest = 3'(k);
        cfound = 1'b1;
      end
    end
  end

  wire [2:0] sel = found ? best : cbest;
  wire loop_volt_ok = found;
  wire pos_volt_ok = above_pct(polar.pos_seq_volt, polar.rated_volt,
                               VOLT_MIN_PCT, 1'b1);
  wire mem_volt_ok = above_pct(mem_volt, polar.rated_volt, VOLT_MIN_PCT, 1'b1);
  wire curr_sufficient = found || cfound;

  wire [ANG_W-1:0] pol_angle = loop_volt_ok ? loops[sel].angle :
    pos_volt_ok ? polar.pos_seq_angle : mem_angle;
  wire volt_sufficient = loop_volt_ok || pos_volt_ok || mem_volt_ok;

  // pre-fault memory updates only while loop voltage is healthy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_volt <= '0;
      mem_angle <= '0;
    end else if (tick && loop_volt_ok) begin
      mem_volt <= loops[sel].volt;
      mem_angle <= loops[sel].angle;
    end
  end

  // backward reverses the window by half a turn
  wire [ANG_W-1:0] half_turn = ANG_W'(1 << (ANG_W - 1));
  wire [ANG_W-1:0] win_lo = (cfg.direction == DIR_BACKWARD) ?
    cfg.angle_lo + half_turn : cfg.angle_lo;
  wire [ANG_W-1:0] win_hi = (cfg.direction == DIR_BACKWARD) ?
    cfg.angle_hi + half_turn : cfg.angle_hi;

  wire angle_ok = volt_sufficient && curr_sufficient &&
                  in_range(pol_angle, win_lo, win_hi);

  // vt failure with option falls back to non-directional
  assign direction_ignored = (cfg.direction == DIR_NONE) ||
                             (vtf_q && cfg.direction_ignored_on_vt_fail) || sotf_q;
  // vt failure disables direction; blocks without option
  assign func_blocked = blk_q || (vtf_q && !cfg.direction_ignored_on_vt_fail);

  wire next_dir = direction_ignored || angle_ok;

  logic [2:0] phase_pick;
  logic [MAG_W-1:0] max_curr;
  always_comb begin
    max_curr = '0;
    for (int p = 0; p < 3; p++) begin
      phase_pick[p] = (cfg.use_rms ? curr_rms[p] : curr_four[p]) >=
                      cfg.start_curr;
      if ((cfg.use_rms ? curr_rms[p] : curr_four[p]) > max_curr)
        max_curr = cfg.use_rms ? curr_rms[p] : curr_four[p];
    end
  end

  wire [2:0] next_start_phase = (func_blocked || !next_dir) ? 3'h0 :
                                phase_pick;
  wire start_cond = |next_start_phase;

  logic delay_done;
  oc_delay_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(start_cond),
    .characteristic(cfg.characteristic),
    .delay_ticks(cfg.delay_ticks),
    .curr(max_curr),
    .start_curr(cfg.start_curr),
    .expired(delay_done)
  );

  wire next_trip = start_cond && (delay_done || sotf_q || trip);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_phase <= 3'h0;
      general_start <= 1'b0;
      trip <= 1'b0;
      dir_ok <= 1'b0;
      lowest_impedance_loop_sel <= LOOP_RESET;
    end else begin
      start_phase <= next_start_phase;
      general_start <= start_cond;
      trip <= next_trip;
      dir_ok <= next_dir && !func_blocked;
      lowest_impedance_loop_sel <= sel;
    end
  end

endmodule : dir_overcurrent_stage

// file: verif/dir_oc_checker.sv
module dir_oc_checker
  import dir_oc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // settings and binary inputs
  input wire dir_oc_pkg::oc_config_t cfg,
  input wire logic block_in,
  input wire logic voltage_circuit_failed,
  input wire logic close_onto_fault_cond,
  // outputs under watch
  input wire logic [2:0] start_phase,
  input wire logic general_start,
  input wire logic trip,
  input wire logic dir_ok,
  input wire logic [2:0] lowest_impedance_loop_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_TRIP_NEEDS_START: assert property (
    trip |-> general_start) else $error("trip without start");
  AST_START_IS_OR: assert property (
    general_start == (|start_phase)) else $error("start not OR");
  AST_START_NEEDS_DIR: assert property (
    general_start |-> dir_ok) else $error("start without direction");
  AST_BLOCK_ALL: assert property (
    block_in[*3] |=> !general_start && !trip && !dir_ok)
    else $error("block ignored");
  AST_VT_FAIL_BLOCK: assert property (
    (voltage_circuit_failed && !cfg.direction_ignored_on_vt_fail)[*3]
    |=> start_phase == 3'h0 && !trip && !dir_ok)
    else $error("vt fail did not block");
  AST_SOTF_FAST: assert property (
    (close_onto_fault_cond && !block_in)[*4] ##0 general_start |-> trip)
    else $error("no fast trip");
  AST_TRIP_DROPS: assert property (
    $fell(general_start) |-> !trip) else $error("trip outlived start");
  AST_TRIP_AFTER_START: assert property (
    (!close_onto_fault_cond)[*4] ##0 $rose(trip) |-> $past(general_start))
    else $error("trip without delay");
  AST_DIRECTION_IGNORED_OK: assert property (
    (cfg.direction == DIR_NONE && !block_in && !voltage_circuit_failed)[*4]
    |=> dir_ok) else $error("ignored direction not true");
  AST_ISOLATED_PP: assert property (
    (cfg.grounding_type_sel == GND_ISOLATED)[*2]
    |=> lowest_impedance_loop_sel < 3'h3) else $error("ground loop chosen");
endmodule : dir_oc_checker

bind dir_overcurrent_stage dir_oc_checker u_dir_oc_checker (
  .clk(clk), .rst_n(rst_n), .cfg(cfg), .block_in(block_in),
  .voltage_circuit_failed(voltage_circuit_failed),
  .close_onto_fault_cond(close_onto_fault_cond),
  .start_phase(start_phase), .general_start(general_start), .trip(trip),
  .dir_ok(dir_ok), .lowest_impedance_loop_sel(lowest_impedance_loop_sel)
);

// file: verif/meas_source.sv
module meas_source
  import dir_oc_pkg::*;
(
  // stimulus from bench
  input wire logic [2:0] low_loop,
  input wire logic [dir_oc_pkg::MAG_W-1:0] volt,
  input wire logic [dir_oc_pkg::MAG_W-1:0] curr,
  input wire logic [dir_oc_pkg::MAG_W-1:0] rms,
  input wire logic [dir_oc_pkg::ANG_W-1:0] angle,
  // measured values
  output dir_oc_pkg::loop_meas_t loops [dir_oc_pkg::NUM_LOOPS],
  output dir_oc_pkg::polar_meas_t polar,
  output logic [dir_oc_pkg::MAG_W-1:0] curr_rms [3],
  output logic [dir_oc_pkg::MAG_W-1:0] curr_four [3]
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    // healthy-phase voltage stays usable
    polar = '{16'h01F4, angle, 16'h03E8, 16'h03E8};
    for (int i = 0; i < NUM_LOOPS; i++) begin
      loops[i] = '{volt, curr, 16'h0384 + 16'(i), angle};
      if (3'(i) == low_loop) begin
        loops[i].imp = 16'h0064;
      end
    end
    for (int p = 0; p < 3; p++) begin
      curr_rms[p] = rms;
      curr_four[p] = curr;
    end
  end
endmodule : meas_source

// file: verif/tb_dir_overcurrent_stage.sv
module tb_dir_overcurrent_stage;
  import dir_oc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [2:0] lo;
    logic [15:0] v, c, r;
    logic [9:0] a;
    dir_mode_t d;
    grounding_t g;
    logic u, ok, st;
    logic [2:0] sel;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic block_in = 1'b0;
  logic vt_fail = 1'b0;
  logic sotf = 1'b0;
  logic [2:0] low_loop, start_phase, sel;
  logic [15:0] volt, curr, rms;
  logic [9:0] angle;
  oc_config_t cfg;
  loop_meas_t loops [NUM_LOOPS];
  polar_meas_t polar;
  logic [15:0] curr_rms [3];
  logic [15:0] curr_four [3];
  logic general_start, trip, dir_ok;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  row_t rows [13] = '{
    '{3'h1, 16'h1F4, 16'h258, 16'h258, 10'h064, DIR_FORWARD, GND_SOLID,
      1'b0, 1'b1, 1'b1, 3'h1},
    '{3'h2, 16'h1F4, 16'h258, 16'h258, 10'h12C, DIR_FORWARD, GND_SOLID,
      1'b0, 1'b0, 1'b0, 3'h2},
    '{3'h3, 16'h1F4, 16'h258, 16'h258, 10'h264, DIR_BACKWARD, GND_SOLID,
      1'b0, 1'b1, 1'b1, 3'h3},
    '{3'h5, 16'h1F4, 16'h258, 16'h258, 10'h064, DIR_BACKWARD, GND_SOLID,
      1'b0, 1'b0, 1'b0, 3'h5},
    '{3'h0, 16'h1F4, 16'h258, 16'h258, 10'h12C, DIR_NONE, GND_SOLID,
      1'b0, 1'b1, 1'b1, 3'h0},
    '{3'h1, 16'h1F4, 16'h190, 16'h190, 10'h064, DIR_FORWARD, GND_SOLID,
      1'b0, 1'b1, 1'b0, 3'h1},
    '{3'h1, 16'h1F4, 16'h04F, 16'h04F, 10'h064, DIR_FORWARD, GND_SOLID,
      1'b0, 1'b0, 1'b0, 3'h0},
    '{3'h1, 16'h1F4, 16'h050, 16'h050, 10'h064, DIR_FORWARD, GND_SOLID,
      1'b0, 1'b1, 1'b0, 3'h1},
    '{3'h1, 16'h032, 16'h258, 16'h258, 10'h064, DIR_FORWARD, GND_SOLID,
      1'b0, 1'b1, 1'b1, 3'h1},
    '{3'h4, 16'h1F4, 16'h258, 16'h258, 10'h064, DIR_FORWARD, GND_ISOLATED,
      1'b0, 1'b1, 1'b1, 3'h0},
    '{3'h4, 16'h1F4, 16'h258, 16'h258, 10'h064, DIR_FORWARD, GND_SOLID,
      1'b0, 1'b1, 1'b1, 3'h4},
    '{3'h1, 16'h1F4, 16'h258, 16'h190, 10'h064, DIR_FORWARD, GND_SOLID,
      1'b1, 1'b1, 1'b0, 3'h1},
    '{3'h1, 16'h1F4, 16'h190, 16'h258, 10'h064, DIR_FORWARD, GND_SOLID,
      1'b1, 1'b1, 1'b1, 3'h1}
  };

  meas_source u_meas_source (.low_loop(low_loop), .volt(volt),
    .curr(curr), .rms(rms), .angle(angle), .loops(loops), .polar(polar),
    .curr_rms(curr_rms), .curr_four(curr_four));
  dir_overcurrent_stage u_dir_overcurrent_stage (.clk(clk), .rst_n(rst_n),
    .loops(loops), .polar(polar), .curr_rms(curr_rms),
    .curr_four(curr_four), .cfg(cfg), .block_in(block_in),
    .voltage_circuit_failed(vt_fail), .close_onto_fault_cond(sotf),
    .start_phase(start_phase), .general_start(general_start),
    .trip(trip), .dir_ok(dir_ok), .lowest_impedance_loop_sel(sel));

  always #10 clk = ~clk;

  task automatic close_out;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic put(input row_t r);
    {low_loop, volt, curr, rms, angle} = {r.lo, r.v, r.c, r.r, r.a};
    cfg.direction = r.d;
    cfg.grounding_type_sel = r.g;
    cfg.use_rms = r.u;
  endtask : put

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask : step

  // hang guard, whole run well under this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    cfg = '{DIR_FORWARD, CHAR_DEFINITE, GND_SOLID, 1'b0, 1'b0, 10'h000,
      10'h0C8, 16'h01F4, 32'h00000001};
    put(rows[0]);
    step(3);
    chk(3'(general_start), 3'h0);
    chk(sel, LOOP_RESET);
    step(1);
    rst_n = 1'b1;
    step(2);
    foreach (rows[i]) begin
      put(rows[i]);
      step(2);
      chk(3'(dir_ok), 3'(rows[i].ok));
      chk(3'(general_start), 3'(rows[i].st));
      chk(sel, rows[i].sel);
      chk(start_phase, {3{rows[i].st}});
    end
    put(rows[0]);
    block_in = 1'b1;
    step(4);
    chk(3'(general_start), 3'h0);
    chk(3'(dir_ok), 3'h0);
    block_in = 1'b0;
    vt_fail = 1'b1;
    step(4);
    chk(3'(general_start), 3'h0);
    put(rows[1]);
    cfg.direction_ignored_on_vt_fail = 1'b1;
    step(4);
    chk(3'(general_start), 3'h1);
    chk(3'(dir_ok), 3'h1);
    vt_fail = 1'b0;
    cfg.direction_ignored_on_vt_fail = 1'b0;
    sotf = 1'b1;
    step(4);
    chk(3'(general_start), 3'h1);
    chk(3'(trip), 3'h1);
    sotf = 1'b0;
    step(4);
    chk(3'(trip), 3'h0);
    put(rows[0]);
    // twice the setting on a very inverse curve: four ticks' worth per tick
    cfg.characteristic = CHAR_VERY_INV;
    cfg.delay_ticks = 32'h00000004;
    curr = 16'h03E8;
    step(4);
    chk(3'(general_start), 3'h1);
    chk(3'(trip), 3'h0);
    n = 0;
    while (trip !== 1'b1 && n < 60000) begin
      step(1);
      n++;
    end
    chk(3'(trip), 3'h1);
    put(rows[5]);
    step(2);
    chk(3'(trip), 3'h0);
    chk(3'(general_start), 3'h0);
    // restart far from a tick: a stale count would trip at once
    put(rows[0]);
    step(4);
    chk(3'(general_start), 3'h1);
    chk(3'(trip), 3'h0);
    close_out();
  end
endmodule : tb_dir_overcurrent_stage
